/* File: design/serializer_ctrl_pkg.sv */
// constants and carrier types of the serializer control register bank
package serializer_ctrl_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] BUS_SLAVE_ADDRESS_OFS = 8'h00;
  localparam logic [7:0] SOFT_RESET_CONTROL_OFS = 8'h01;
  localparam logic [7:0] GENERAL_CONFIGURATION_OFS = 8'h02;
  localparam logic [7:0] OPERATING_MODE_SELECT_OFS = 8'h03;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ADDRESS_OVERRIDE_POS = 0;
  localparam int SLAVE_ADDRESS_LSB = 1;
  localparam int LOGIC_RESET_POS = 0;
  localparam int FULL_RESET_POS = 1;
  localparam int ROM_RELOAD_POS = 2;
  localparam int BUS_VOLTAGE_POS = 0;
  localparam int CRC_ENABLE_POS = 1;
  localparam int LANE_COUNT_LSB = 4;
  localparam int CLOCK_LANE_POS = 6;
  localparam int MODE_LSB = 0;
  localparam int MODE_DONE_POS = 3;
  localparam int MODE_OVERRIDE_POS = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic ADDRESS_OVERRIDE_RST = 1'h0;
  localparam logic [6:0] SLAVE_ADDRESS_RST = 7'h00;
  localparam logic [2:0] SOFT_RESET_RST = 3'h0;
  localparam logic CLOCK_LANE_RST = 1'h0;
  localparam logic [1:0] LANE_COUNT_RST = 2'h3;
  localparam logic [1:0] LANE_COUNT_RESERVED = 2'h2;
  localparam logic CRC_ENABLE_RST = 1'h1;
  localparam logic BUS_VOLTAGE_RST = 1'h0;
  localparam logic MODE_OVERRIDE_RST = 1'h0;
  localparam logic MODE_DONE_RST = 1'h0;

  // ---------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    mode_sync_camera = 3'b000,
    mode_reserved_one = 3'b001,
    mode_async_ext_clock = 3'b010,
    mode_async_int_clock = 3'b011,
    mode_reserved_four = 3'b100,
    mode_parallel_ext_clock = 3'b101,
    mode_reserved_six = 3'b110,
    mode_reserved_seven = 3'b111
  } mode_type;

  localparam mode_type MODE_RST = mode_sync_camera;

  // ---------------------------------------------------------------
  // access carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } access_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } access_rsp_type;

endpackage : serializer_ctrl_pkg

/* File: design/power_down_mode_latch.sv */
// catches the strapped mode on a rising edge of the power-down input
`timescale 1ns/100ps
`default_nettype none
module power_down_mode_latch (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // pins
  input wire logic power_down_input_i,
  input wire serializer_ctrl_pkg::mode_type mode_strap_i,
  // capture
  output logic latch_pulse_o,
  output serializer_ctrl_pkg::mode_type latched_mode_o
);
  import serializer_ctrl_pkg::*;

  logic pdb_prev;

  // ---------------------------------------------------------------
  // edge detect
  // ---------------------------------------------------------------
  // previous level resets low so a high pin after reset counts as start-up
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pdb_prev <= 1'b0;
      latch_pulse_o <= 1'b0;
      latched_mode_o <= MODE_RST;
    end else begin
      pdb_prev <= power_down_input_i;
      latch_pulse_o <= power_down_input_i && !pdb_prev;
      if (power_down_input_i && !pdb_prev) begin
        latched_mode_o <= mode_strap_i;
      end
    end
  end

endmodule : power_down_mode_latch
`default_nettype wire

/* File: design/serializer_core_control_regs.sv */
// control register bank: slave address, soft resets, lane setup, mode select
// ---------------------------------------------------------------
// How it works
// - address field shows current address, writable when overridden
// - override bit picks register or strap address
// - rom reload bit triggers reload, self-clears
// - full reset bit resets logic and registers
// - logic reset bit resets logic, keeps registers
// - bit six selects continuous clock lane
// - lane field picks one, two, four lanes
// - voltage bit loads from index strap
// - mode override bit picks register or strap mode
// - mode done flag set once mode latched
// - mode field shows active mode, writable overridden
// - strap mode captured on power-down rising edge
// - written mode codes limited to the four defined modes, strap code taken unchecked
// - self-clearing bits return to zero after action
// - strap fields load from pins at start-up
// ---------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module serializer_core_control_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // strap pins
  input wire logic [6:0] address_strap_i,
  input wire logic index_strap_pin_i,
  input wire serializer_ctrl_pkg::mode_type mode_strap_i,
  input wire logic power_down_input_i,
  // register access, local control bus and remote back channel
  input wire serializer_ctrl_pkg::access_req_type local_req_i,
  output serializer_ctrl_pkg::access_rsp_type local_rsp_o,
  input wire serializer_ctrl_pkg::access_req_type remote_req_i,
  output serializer_ctrl_pkg::access_rsp_type remote_rsp_o,
  // configuration outputs
  output logic [6:0] slave_address_o,
  output logic clock_lane_continuous_o,
  output logic [1:0] lane_count_o,
  output logic crc_enable_o,
  output logic bus_voltage_o,
  output serializer_ctrl_pkg::mode_type active_mode_o,
  output logic mode_done_o,
  // action pulses
  output logic rom_reload_o,
  output logic full_reset_o,
  output logic logic_reset_o
);
  import serializer_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic strap_load;
  logic [6:0] strap_address;
  logic address_override_bit;
  logic [6:0] written_address;
  logic [2:0] soft_reset;
  logic mode_override_bit;
  logic latch_pulse;
  mode_type latched_mode;
  logic reg_clear;
  logic logic_clear;
  access_req_type wr_req;
  logic wr_any;
  logic wr0;
  logic wr1;
  logic wr2;
  logic wr3;
  logic wr2_remote;
  logic [6:0] next_slave_address;

  function automatic logic mode_is_defined(input logic [2:0] code);
    case (code)
      mode_sync_camera,
      mode_async_ext_clock,
      mode_async_int_clock,
      mode_parallel_ext_clock: mode_is_defined = 1'b1;
      default: mode_is_defined = 1'b0;
    endcase
  endfunction : mode_is_defined

  // ---------------------------------------------------------------
  // resets and write select
  // ---------------------------------------------------------------
  assign reg_clear = !rstn_i || soft_reset[FULL_RESET_POS];
  assign logic_clear = reg_clear || soft_reset[LOGIC_RESET_POS];

  // remote write wins when both ports write in one cycle
  always_comb begin
    wr_req = remote_req_i.valid && remote_req_i.write ? remote_req_i : local_req_i;
    wr_any = wr_req.valid && wr_req.write;
    wr0 = wr_any && wr_req.addr == BUS_SLAVE_ADDRESS_OFS;
    wr1 = wr_any && wr_req.addr == SOFT_RESET_CONTROL_OFS;
    wr2 = wr_any && wr_req.addr == GENERAL_CONFIGURATION_OFS;
    wr3 = wr_any && wr_req.addr == OPERATING_MODE_SELECT_OFS;
    wr2_remote = remote_req_i.valid && remote_req_i.write && remote_req_i.addr == GENERAL_CONFIGURATION_OFS;
  end

  // strap fields load in the first cycle after any register reset
  always_ff @(posedge clk_i) begin
    if (reg_clear) begin
      strap_load <= 1'b1;
    end else begin
      strap_load <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // bus slave address
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reg_clear) begin
      strap_address <= SLAVE_ADDRESS_RST;
      address_override_bit <= ADDRESS_OVERRIDE_RST;
      written_address <= SLAVE_ADDRESS_RST;
    end else begin
      if (strap_load) begin
        strap_address <= address_strap_i;
      end
      if (wr0) begin
        address_override_bit <= wr_req.wdata[ADDRESS_OVERRIDE_POS];
        if (address_override_bit) begin
          written_address <= wr_req.wdata[7:SLAVE_ADDRESS_LSB];
        end
      end
    end
  end

  assign next_slave_address = address_override_bit ? written_address : strap_address;

  always_ff @(posedge clk_i) begin
    if (reg_clear) begin
      slave_address_o <= SLAVE_ADDRESS_RST;
    end else begin
      slave_address_o <= next_slave_address;
    end
  end

  // ---------------------------------------------------------------
  // soft reset control
  // ---------------------------------------------------------------
  // each bit lives for one cycle: that cycle is the action pulse
  always_ff @(posedge clk_i) begin
    if (reg_clear) begin
      soft_reset <= SOFT_RESET_RST;
    end else if (wr1) begin
      soft_reset <= wr_req.wdata[2:0];
    end else begin
      soft_reset <= SOFT_RESET_RST;
    end
  end

  assign rom_reload_o = soft_reset[ROM_RELOAD_POS];
  assign full_reset_o = soft_reset[FULL_RESET_POS];
  assign logic_reset_o = soft_reset[LOGIC_RESET_POS];

  // ---------------------------------------------------------------
  // general configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reg_clear) begin
      clock_lane_continuous_o <= CLOCK_LANE_RST;
      lane_count_o <= LANE_COUNT_RST;
      crc_enable_o <= CRC_ENABLE_RST;
    end else if (wr2) begin
      clock_lane_continuous_o <= wr_req.wdata[CLOCK_LANE_POS];
      crc_enable_o <= wr_req.wdata[CRC_ENABLE_POS];
      if (wr_req.wdata[LANE_COUNT_LSB +: 2] != LANE_COUNT_RESERVED) begin
        lane_count_o <= wr_req.wdata[LANE_COUNT_LSB +: 2];
      end
    end
  end

  // besides reset and the strap load, the voltage level only moves through the back channel
  always_ff @(posedge clk_i) begin
    if (reg_clear) begin
      bus_voltage_o <= BUS_VOLTAGE_RST;
    end else if (strap_load) begin
      bus_voltage_o <= index_strap_pin_i;
    end else if (wr2_remote) begin
      bus_voltage_o <= remote_req_i.wdata[BUS_VOLTAGE_POS];
    end
  end

  // ---------------------------------------------------------------
  // operating mode select
  // ---------------------------------------------------------------
  power_down_mode_latch u_mode_latch (
    .clk_i(clk_i),
    .rstn_i(!logic_clear),
    .power_down_input_i(power_down_input_i),
    .mode_strap_i(mode_strap_i),
    .latch_pulse_o(latch_pulse),
    .latched_mode_o(latched_mode)
  );

  always_ff @(posedge clk_i) begin
    if (reg_clear) begin
      mode_override_bit <= MODE_OVERRIDE_RST;
      active_mode_o <= MODE_RST;
      mode_done_o <= MODE_DONE_RST;
    end else begin
      if (wr3) begin
        mode_override_bit <= wr_req.wdata[MODE_OVERRIDE_POS];
      end
      if (mode_override_bit) begin
        if (wr3 && mode_is_defined(wr_req.wdata[MODE_LSB +: 3])) begin
          active_mode_o <= mode_type'(wr_req.wdata[MODE_LSB +: 3]);
        end
      end else if (latch_pulse) begin
        active_mode_o <= latched_mode;
        mode_done_o <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    read_reg = 8'h00;
    case (addr)
      BUS_SLAVE_ADDRESS_OFS: read_reg = {next_slave_address, address_override_bit};
      SOFT_RESET_CONTROL_OFS: read_reg = {5'h00, soft_reset};
      GENERAL_CONFIGURATION_OFS: read_reg = {1'b0, clock_lane_continuous_o, lane_count_o, 2'h0, crc_enable_o,
                                             bus_voltage_o};
      OPERATING_MODE_SELECT_OFS: read_reg = {3'h0, mode_override_bit, mode_done_o, active_mode_o};
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  always_ff @(posedge clk_i) begin
    if (logic_clear) begin
      local_rsp_o <= '0;
      remote_rsp_o <= '0;
    end else begin
      local_rsp_o.valid <= local_req_i.valid && !local_req_i.write;
      local_rsp_o.data <= read_reg(local_req_i.addr);
      remote_rsp_o.valid <= remote_req_i.valid && !remote_req_i.write;
      remote_rsp_o.data <= read_reg(remote_req_i.addr);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_rom_pulse;
    rom_reload_o && !wr1;
  endsequence

  sequence s_pdb_rise;
    $rose(power_down_input_i) && !mode_override_bit && !logic_clear;
  endsequence

  sequence s_quiet_mode;
    !mode_override_bit && !reg_clear && !wr3;
  endsequence

  chk_rom_self_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_rom_pulse |=> !rom_reload_o)
    else $error("rom reload bit did not clear");

  chk_full_reset_regs: assert property (@(posedge clk_i) disable iff (!rstn_i)
    full_reset_o |=> lane_count_o == LANE_COUNT_RST && crc_enable_o && !mode_override_bit && !full_reset_o)
    else $error("full reset left registers set");

  chk_logic_keeps_regs: assert property (@(posedge clk_i) disable iff (!rstn_i)
    logic_reset_o && !full_reset_o && !wr2 |=> $stable(lane_count_o) && $stable(crc_enable_o))
    else $error("logic reset changed registers");

  chk_address_strap: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !reg_clear && !address_override_bit |=> slave_address_o == $past(strap_address))
    else $error("strapped slave address not used");

  chk_address_select: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !reg_clear && address_override_bit |=> slave_address_o == $past(written_address))
    else $error("written slave address not used");

  chk_clock_lane_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr2 && !reg_clear |=> clock_lane_continuous_o == $past(wr_req.wdata[CLOCK_LANE_POS]))
    else $error("clock lane bit not written");

  chk_lane_reserved: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr2 && !reg_clear && wr_req.wdata[5:4] == LANE_COUNT_RESERVED |=> $stable(lane_count_o))
    else $error("reserved lane code accepted");

  chk_voltage_local: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !reg_clear && !strap_load && !wr2_remote |=> $stable(bus_voltage_o))
    else $error("voltage bit moved without remote write");

  chk_mode_latch: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_pdb_rise ##1 s_quiet_mode |=> mode_done_o && active_mode_o == $past(mode_strap_i, 2))
    else $error("strap mode not latched");

  chk_mode_override_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mode_override_bit && !wr3 && !reg_clear |=> $stable(active_mode_o))
    else $error("overridden mode changed");

  chk_mode_defined: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !reg_clear |=> mode_is_defined(active_mode_o))
    else $error("reserved mode became active");

endmodule : serializer_core_control_regs
`default_nettype wire

/* File: verification/deser_host_model.sv */
// back-channel host model issuing remote register accesses
`timescale 1ns/100ps
`default_nettype none
module deser_host_model (
  // clock
  input wire logic clk_i,
  // remote access
  output var serializer_ctrl_pkg::access_req_type remote_req_o
);
  import serializer_ctrl_pkg::*;
  initial remote_req_o = '0;
  // besides reset and the strap load, the bus voltage bit is only changed through this path
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    remote_req_o = '{1'b1, w, a, d};
    @(negedge clk_i);
    remote_req_o = '{1'b0, ~w, ~a, ~d};
  endtask : access
endmodule : deser_host_model
`default_nettype wire

/* File: verification/serializer_core_control_regs_test.sv */
// self-checking bench for the serializer control register bank
`timescale 1ns/100ps
`default_nettype none
module serializer_core_control_regs_test;
  import serializer_ctrl_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [6:0] address_strap = 7'h00;
  logic index_strap = 1'b0;
  mode_type mode_strap = mode_sync_camera;
  logic power_down = 1'b0;
  access_req_type local_req = '0;
  access_req_type remote_req;
  access_rsp_type local_rsp;
  access_rsp_type remote_rsp;
  logic [6:0] slave_address;
  logic clock_lane_continuous;
  logic [1:0] lane_count;
  logic crc_enable;
  logic bus_voltage;
  mode_type active_mode;
  logic mode_done;
  logic rom_reload;
  logic full_reset;
  logic logic_reset;
  logic [2:0] pulses;
  logic [7:0] exp_q[$];
  logic [7:0] seen;
  logic [7:0] cfg;
  logic [6:0] new_addr;
  logic [1:0] lane_exp;
  logic [1:0] codes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  mode_type modes [4] = '{mode_sync_camera, mode_async_ext_clock, mode_async_int_clock, mode_parallel_ext_clock};
  mode_type mode_exp;
  logic [31:0] rnd = 32'h93467781;
  int cnt;
  int n_mismatch = 0;
  int check_count = 0;

  always #5 clk_i = ~clk_i;
  assign pulses = {rom_reload, full_reset, logic_reset};

  serializer_core_control_regs dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .address_strap_i(address_strap), .index_strap_pin_i(index_strap),
    .mode_strap_i(mode_strap), .power_down_input_i(power_down),
    .local_req_i(local_req), .local_rsp_o(local_rsp),
    .remote_req_i(remote_req), .remote_rsp_o(remote_rsp),
    .slave_address_o(slave_address), .clock_lane_continuous_o(clock_lane_continuous),
    .lane_count_o(lane_count), .crc_enable_o(crc_enable), .bus_voltage_o(bus_voltage),
    .active_mode_o(active_mode), .mode_done_o(mode_done),
    .rom_reload_o(rom_reload), .full_reset_o(full_reset), .logic_reset_o(logic_reset)
  );
  deser_host_model partner_u (.clk_i(clk_i), .remote_req_o(remote_req));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic bus(input logic rmt, input logic w, input logic [7:0] a, input logic [7:0] d);
    if (rmt) begin
      partner_u.access(w, a, d);
    end else begin
      @(negedge clk_i);
      local_req = '{1'b1, w, a, d};
      @(negedge clk_i);
      local_req = '{1'b0, ~w, ~a, ~d};
    end
  endtask : bus

  task automatic rd(input logic rmt, input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(rmt, 1'b0, a, 8'h00);
    @(negedge clk_i);
  endtask : rd

  task automatic stop_test();
    if (exp_q.size() != 0) n_mismatch++;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // --------------------------------------------------------------
  // response monitor
  // --------------------------------------------------------------
  always @(negedge clk_i) begin
    if (local_rsp.valid === 1'b1 || remote_rsp.valid === 1'b1) begin
      seen = (local_rsp.valid === 1'b1) ? local_rsp.data : remote_rsp.data;
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[FAIL] response expected none seen %h", seen);
      end else begin
        check("read data", seen, exp_q.pop_front());
      end
    end
  end

  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    rnd = xorshift(rnd);
    address_strap = rnd[6:0];
    index_strap = rnd[7];
    repeat (8) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check("slave address", {1'b0, slave_address}, {1'b0, address_strap});
    check("lane count", {6'h00, lane_count}, 8'h03);
    check("crc enable", {7'h00, crc_enable}, 8'h01);
    check("bus voltage", {7'h00, bus_voltage}, {7'h00, index_strap});
    rd(1'b0, BUS_SLAVE_ADDRESS_OFS, {address_strap, 1'b0});
    rd(1'b1, SOFT_RESET_CONTROL_OFS, 8'h00);
    rd(1'b0, GENERAL_CONFIGURATION_OFS, {7'h19, index_strap});
    rd(1'b0, OPERATING_MODE_SELECT_OFS, 8'h00);
    bus(1'b0, 1'b1, 8'h07, 8'hff);
    rd(1'b0, 8'h07, 8'h00);
    // address override needs the override bit set before the field takes a write
    rnd = xorshift(rnd);
    new_addr = rnd[6:0] ^ 7'h55;
    bus(1'b0, 1'b1, BUS_SLAVE_ADDRESS_OFS, {new_addr, 1'b0});
    rd(1'b0, BUS_SLAVE_ADDRESS_OFS, {address_strap, 1'b0});
    bus(1'b0, 1'b1, BUS_SLAVE_ADDRESS_OFS, {new_addr, 1'b1});
    bus(1'b0, 1'b1, BUS_SLAVE_ADDRESS_OFS, {new_addr, 1'b1});
    rd(1'b0, BUS_SLAVE_ADDRESS_OFS, {new_addr, 1'b1});
    check("override address", {1'b0, slave_address}, {1'b0, new_addr});
    bus(1'b0, 1'b1, BUS_SLAVE_ADDRESS_OFS, {new_addr, 1'b0});
    rd(1'b0, BUS_SLAVE_ADDRESS_OFS, {address_strap, 1'b0});
    check("strap address", {1'b0, slave_address}, {1'b0, address_strap});
    // lane codes, the reserved one last; local voltage writes must not land
    lane_exp = 2'h3;
    for (int k = 0; k < 4; k++) begin
      if (codes[k] != LANE_COUNT_RESERVED) lane_exp = codes[k];
      bus(1'b0, 1'b1, GENERAL_CONFIGURATION_OFS, {2'b01, codes[k], 3'b000, ~index_strap});
      @(negedge clk_i);
      check("lane count", {6'h00, lane_count}, {6'h00, lane_exp});
      check("clock lane", {7'h00, clock_lane_continuous}, 8'h01);
      rd(1'b0, GENERAL_CONFIGURATION_OFS, {2'b01, lane_exp, 3'b000, index_strap});
    end
    bus(1'b1, 1'b1, GENERAL_CONFIGURATION_OFS, {6'h04, 1'b1, ~index_strap});
    @(negedge clk_i);
    check("remote voltage", {7'h00, bus_voltage}, {7'h00, ~index_strap});
    check("clock lane", {7'h00, clock_lane_continuous}, 8'h00);
    // simultaneous writes: the remote one wins
    cfg = {6'h00, 1'b1, ~index_strap};
    fork
      bus(1'b0, 1'b1, GENERAL_CONFIGURATION_OFS, 8'h72);
      bus(1'b1, 1'b1, GENERAL_CONFIGURATION_OFS, cfg);
    join
    rd(1'b0, GENERAL_CONFIGURATION_OFS, cfg);
    // soft resets: logic, full, rom reload
    for (int i = 0; i < 3; i++) begin
      cnt = 0;
      fork
        bus(1'b0, 1'b1, SOFT_RESET_CONTROL_OFS, 8'h01 << i);
        begin
          repeat (5) begin
            @(negedge clk_i);
            cnt += pulses[i];
          end
        end
      join
      check("reset pulse", cnt[7:0], 8'h01);
      repeat (4) @(negedge clk_i);
      rd(1'b0, SOFT_RESET_CONTROL_OFS, 8'h00);
      rd(1'b0, GENERAL_CONFIGURATION_OFS, (i == 0) ? cfg : {7'h19, index_strap});
    end
    // strap mode captured on the power-down rise
    rnd = xorshift(rnd);
    mode_strap = modes[1 + (rnd % 32'd3)];
    power_down = 1'b1;
    repeat (3) @(negedge clk_i);
    check("latched mode", {5'h00, active_mode}, {5'h00, mode_strap});
    check("mode done", {7'h00, mode_done}, 8'h01);
    rd(1'b0, OPERATING_MODE_SELECT_OFS, {5'h01, mode_strap});
    // register override of the mode, every code
    mode_exp = mode_strap;
    bus(1'b0, 1'b1, OPERATING_MODE_SELECT_OFS, 8'h10);
    for (int c = 0; c < 8; c++) begin
      if (!(c inside {1, 4, 6, 7})) mode_exp = mode_type'(c[2:0]);
      bus(1'b0, 1'b1, OPERATING_MODE_SELECT_OFS, {5'h02, c[2:0]});
      @(negedge clk_i);
      check("override mode", {5'h00, active_mode}, {5'h00, mode_exp});
      rd(1'b0, OPERATING_MODE_SELECT_OFS, {5'h03, mode_exp});
    end
    power_down = 1'b0;
    @(negedge clk_i);
    mode_strap = (mode_exp == mode_sync_camera) ? mode_async_ext_clock : mode_sync_camera;
    power_down = 1'b1;
    repeat (3) @(negedge clk_i);
    check("override kept", {5'h00, active_mode}, {5'h00, mode_exp});
    stop_test();
  end
endmodule : serializer_core_control_regs_test
`default_nettype wire
